// >>> verilog/tsp_pkg.sv
// shared constants and types of the segmented transmit packet input
// assumes both ends run on one clock and are joined by tsp_if
package tsp_pkg;

    // ****************************************
    // segmented bus shape
    // ****************************************
    localparam int SEGS      = 2;
    localparam int DATA_W    = 128;
    localparam int CHAN_W    = 11;
    localparam int MTY_W     = 4;
    localparam int SEG_BYTES = 16;

    // ****************************************
    // device buffer and burst defaults
    // ****************************************
    localparam int FIFO_DEPTH      = 8;
    localparam int RDY_THRESH      = 4;
    localparam int MAX_BURST_WORDS = 16;

    // ****************************************
    // source register map (word index)
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CHAN = 4'h1;
    localparam logic [3:0] REG_LEN  = 4'h2;
    localparam logic [3:0] REG_STAT = 4'h3;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam int CTRL_GO   = 0;
    localparam int CTRL_BCTL = 1;
    localparam int CTRL_ERR  = 2;
    localparam int ST_DONE   = 0;
    localparam int ST_OVF    = 1;
    localparam int ST_BUSY   = 2;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // one segment of the bus
    typedef struct packed {
        logic              vld;
        logic              sop;
        logic              eop;
        logic              err;
        logic              bctl;
        logic [MTY_W-1:0]  mty;
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
    } tsp_seg_t;

    // empty count as the device honours it on a closing transfer
    function automatic logic [MTY_W-1:0] tsp_eff_mty(
        input logic             eop,
        input logic             err,
        input logic [MTY_W-1:0] mty
    );
        if (!eop)
            return 4'h0;
        return err ? {mty[3], 3'h0} : mty;
    endfunction

endpackage

// >>> verilog/tsp_if.sv
// segmented user bus between packet source and transmit input
// assumes both ends share one clock; no clocking here
`timescale 1ns/1ns
interface tsp_if;
    tsp_pkg::tsp_seg_t [tsp_pkg::SEGS-1:0] seg;
    logic                                  rdy;
    logic                                  ovf;

    modport dev
    (
        input  seg,
        output rdy,
        output ovf
    );

    modport src
    (
        output seg,
        input  rdy,
        input  ovf
    );
endinterface

// >>> verilog/tsp_dev.sv
// transmit input end: takes two bus segments a cycle, buffers them in
// order and emits one word a cycle with burst control words inserted
// assumes the source runs on i_ref_clk and the drain may stall it
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ns

module tsp_dev #(
    parameter int DEPTH     = tsp_pkg::FIFO_DEPTH,
    parameter int THRESH    = tsp_pkg::RDY_THRESH,
    parameter int MAX_BURST = tsp_pkg::MAX_BURST_WORDS
)
(
    // clock and reset
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_rst_n,
    // segmented bus
    tsp_if.dev                               bus,
    // configuration
    input  wire logic [tsp_pkg::CHAN_W-1:0]  i_channel_range_cfg,
    // outgoing word stream
    input  wire logic                        i_out_rdy,
    output logic                             o_out_vld,
    output logic                             o_out_bcw,
    output logic                             o_out_sop,
    output logic                             o_out_eop,
    output logic                             o_out_err,
    output logic [tsp_pkg::MTY_W-1:0]        o_out_mty,
    output logic [tsp_pkg::CHAN_W-1:0]       o_out_chan,
    output logic [tsp_pkg::DATA_W-1:0]       o_out_data,
    // status
    output logic                             o_chan_bad
);
    localparam int AW = $clog2(DEPTH);

    // ****************************************
    // elaboration checks
    // ****************************************
    // two staged segments plus two new ones must always fit
    if (DEPTH < 4 || (1 << AW) != DEPTH || THRESH < 4 || THRESH > DEPTH
        || MAX_BURST < 1 || MAX_BURST > 255)
    begin : g_bad_param
        $error("tsp_dev: unsupported DEPTH, THRESH or MAX_BURST");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [tsp_pkg::DATA_W-1:0] data;
        logic [tsp_pkg::CHAN_W-1:0] chan;
        logic                       sop;
        logic                       eop;
        logic                       err;
        logic                       bctl;
        logic [tsp_pkg::MTY_W-1:0]  mty;
    } tsp_ent_t;

    typedef struct packed {
        tsp_pkg::tsp_seg_t [tsp_pkg::SEGS-1:0] stg;
        logic                                  rdy_seen;
        tsp_ent_t [DEPTH-1:0]                  mem;
        logic [AW:0]                           wp;
        logic [AW:0]                           rp;
        logic [7:0]                            bcnt;
        logic                                  bcw_sent;
        logic                                  vld;
        logic                                  bcw;
        logic                                  sop;
        logic                                  eop;
        logic                                  err;
        logic [tsp_pkg::MTY_W-1:0]             mty;
        logic [tsp_pkg::CHAN_W-1:0]            chan;
        logic [tsp_pkg::DATA_W-1:0]            data;
        logic                                  ovf;
        logic                                  chan_bad;
    } tsp_dev_st_t;

    tsp_dev_st_t q;
    tsp_dev_st_t d;
    logic [AW:0] used;
    logic        rdy;

    function automatic tsp_ent_t to_ent(input tsp_pkg::tsp_seg_t s);
        tsp_ent_t e;
        e.data = s.data;
        e.chan = s.chan;
        e.sop  = s.sop;
        e.eop  = s.eop;
        e.err  = s.err;
        e.bctl = s.bctl;
        e.mty  = s.mty;
        return e;
    endfunction

    // ****************************************
    // back-pressure
    // ****************************************
    assign used = q.wp - q.rp;
    // ready judged on committed fill only; the staged pair is covered by THRESH
    assign rdy     = ((AW + 1)'(DEPTH) - used) >= (AW + 1)'(THRESH);
    assign bus.rdy = rdy;
    assign bus.ovf = q.ovf;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [AW:0] wp;
        logic [AW:0] fill;
        tsp_ent_t    e;
        d        = q;
        wp       = q.wp;
        fill     = used;
        e        = '0;
        d.ovf      = 1'b0;
        d.chan_bad = 1'b0;

        // staged segments enter the buffer, segment zero first
        for (int s = 0; s < tsp_pkg::SEGS; s++)
        begin
            if (q.stg[s].vld)
            begin
                if (fill < (AW + 1)'(DEPTH))
                begin
                    d.mem[wp[AW-1:0]] = to_ent(q.stg[s]);
                    wp   = wp + 1'b1;
                    fill = fill + 1'b1;
                end
                else
                begin
                    d.ovf = 1'b1;
                end
                if (q.stg[s].chan > i_channel_range_cfg)
                begin
                    d.chan_bad = 1'b1;
                end
            end
        end
        if ((q.stg[0].vld || q.stg[1].vld) && !q.rdy_seen)
        begin
            d.ovf = 1'b1;
        end
        d.wp = wp;

        // capture each segment on its own valid only
        for (int s = 0; s < tsp_pkg::SEGS; s++)
        begin
            d.stg[s].vld = bus.seg[s].vld;
            if (bus.seg[s].vld)
            begin
                d.stg[s] = bus.seg[s];
            end
        end
        d.rdy_seen = rdy;

        // output word: control word ahead of payload when due
        if (!q.vld || i_out_rdy)
        begin
            d.vld = 1'b0;
            d.bcw = 1'b0;
            if (q.wp != q.rp)
            begin
                e = q.mem[q.rp[AW-1:0]];
                if (!q.bcw_sent && (e.sop || e.bctl
                    || q.bcnt >= 8'(MAX_BURST)))
                begin
                    d.vld      = 1'b1;
                    d.bcw      = 1'b1;
                    d.sop      = 1'b0;
                    d.eop      = 1'b0;
                    d.err      = 1'b0;
                    d.mty      = 4'h0;
                    d.chan     = e.chan;
                    d.data     = '0;
                    d.bcw_sent = 1'b1;
                    d.bcnt     = 8'h0;
                end
                else
                begin
                    d.vld  = 1'b1;
                    d.sop  = e.sop;
                    d.eop  = e.eop;
                    d.err  = e.eop & e.err;
                    d.mty  = tsp_pkg::tsp_eff_mty(e.eop, e.err, e.mty);
                    d.chan = e.chan;
                    d.data = e.data;
                    d.rp   = q.rp + 1'b1;
                    d.bcw_sent = 1'b0;
                    if (q.bcnt != 8'hff)
                    begin
                        d.bcnt = q.bcnt + 8'h1;
                    end
                end
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_out_vld  = q.vld;
    assign o_out_bcw  = q.bcw;
    assign o_out_sop  = q.sop;
    assign o_out_eop  = q.eop;
    assign o_out_err  = q.err;
    assign o_out_mty  = q.mty;
    assign o_out_chan = q.chan;
    assign o_out_data = q.data;
    assign o_chan_bad = q.chan_bad;

endmodule

// >>> verilog/tsp_src.sv
// packet source end: software programs channel, length and flags,
// then starts a packet that is cut into segments of the bus
// assumes the input end answers ready on the same clock
`timescale 1ns/1ns
module tsp_src
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // segmented bus
    tsp_if.src               bus,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic                                  bctl_en;
        logic                                  err_en;
        logic [tsp_pkg::CHAN_W-1:0]            chan;
        logic [15:0]                           len;
        logic [1:0]                            stat;
        logic [1:0]                            mask;
        logic [31:0]                           rdata;
        logic                                  busy;
        logic                                  first;
        logic [15:0]                           rem;
        logic [7:0]                            pat;
        tsp_pkg::tsp_seg_t [tsp_pkg::SEGS-1:0] seg;
    } tsp_src_st_t;

    tsp_src_st_t q;
    tsp_src_st_t d;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [1:0] ev;
        logic [4:0] nb;
        ev = 2'h0;
        nb = 5'h0;
        d  = q;
        d.rdata = 32'h0;

        // refill only once the held segments were taken
        if (!(q.seg[0].vld || q.seg[1].vld) || bus.rdy)
        begin
            for (int s = 0; s < tsp_pkg::SEGS; s++)
            begin
                d.seg[s].vld = 1'b0;
                if (d.busy && d.rem != 16'h0)
                begin
                    nb = (d.rem > 16'(tsp_pkg::SEG_BYTES)) ?
                         5'(tsp_pkg::SEG_BYTES) : d.rem[4:0];
                    d.seg[s].vld  = 1'b1;
                    d.seg[s].sop  = d.first;
                    d.seg[s].eop  = (d.rem == 16'(nb));
                    d.seg[s].err  = d.seg[s].eop & q.err_en;
                    // forcing every transfer lets the drain see each request
                    d.seg[s].bctl = q.bctl_en;
                    d.seg[s].mty  = 4'(5'(tsp_pkg::SEG_BYTES) - nb);
                    d.seg[s].chan = q.chan;
                    for (int b = 0; b < tsp_pkg::SEG_BYTES; b++)
                    begin
                        d.seg[s].data[127 - 8 * b -: 8] = d.pat + 8'(b);
                    end
                    d.pat   = d.pat + 8'h10;
                    d.rem   = d.rem - 16'(nb);
                    d.first = 1'b0;
                    if (d.seg[s].eop)
                    begin
                        d.busy = 1'b0;
                        ev[tsp_pkg::ST_DONE] = 1'b1;
                    end
                end
            end
        end
        ev[tsp_pkg::ST_OVF] = bus.ovf;

        if (i_wr)
        begin
            unique case (i_addr)
                tsp_pkg::REG_CTRL:
                begin
                    d.bctl_en = i_wdata[tsp_pkg::CTRL_BCTL];
                    d.err_en  = i_wdata[tsp_pkg::CTRL_ERR];
                    // a start while busy or with zero length is ignored
                    if (i_wdata[tsp_pkg::CTRL_GO] && !q.busy && q.len != 16'h0)
                    begin
                        d.busy  = 1'b1;
                        d.first = 1'b1;
                        d.rem   = q.len;
                        d.pat   = 8'h0;
                    end
                end
                tsp_pkg::REG_CHAN: d.chan = i_wdata[tsp_pkg::CHAN_W-1:0];
                tsp_pkg::REG_LEN:  d.len  = i_wdata[15:0];
                tsp_pkg::REG_STAT: d.stat = q.stat & ~i_wdata[1:0];
                tsp_pkg::REG_MASK: d.mask = i_wdata[1:0];
                default: ;
            endcase
        end
        // a new event outweighs a clear in the same cycle
        d.stat = d.stat | ev;

        if (i_rd)
        begin
            unique case (i_addr)
                tsp_pkg::REG_CTRL: d.rdata = {29'h0, q.err_en, q.bctl_en, 1'b0};
                tsp_pkg::REG_CHAN: d.rdata = {21'h0, q.chan};
                tsp_pkg::REG_LEN:  d.rdata = {16'h0, q.len};
                tsp_pkg::REG_STAT: d.rdata = {29'h0, q.busy, q.stat};
                tsp_pkg::REG_MASK: d.rdata = {30'h0, q.mask};
                default:           d.rdata = 32'h0;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q      <= '0;
            q.stat <= tsp_pkg::STAT_RST;
            q.mask <= tsp_pkg::MASK_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // valid is withheld while ready is low; data stay registered
    always_comb
    begin
        bus.seg = q.seg;
        for (int s = 0; s < tsp_pkg::SEGS; s++)
        begin
            bus.seg[s].vld = q.seg[s].vld & bus.rdy;
        end
    end

    assign o_rdata = q.rdata;
    assign o_irq   = |(q.stat & q.mask);

endmodule

// >>> test/tsp_chk_sva.sv
// checker of the segmented bus and of the input end's word stream
// assumes tb instantiates it beside the interface; one clock domain
`timescale 1ns/1ns
module tsp_chk
(
    // clock and reset
    input wire logic                                  i_ref_clk,
    input wire logic                                  i_rst_n,
    // segmented bus
    input wire tsp_pkg::tsp_seg_t [tsp_pkg::SEGS-1:0] seg,
    input wire logic                                  rdy,
    input wire logic                                  ovf,
    // word stream
    input wire logic                                  i_out_rdy,
    input wire logic                                  o_out_vld,
    input wire logic                                  o_out_bcw,
    input wire logic                                  o_out_sop,
    input wire logic                                  o_out_eop,
    input wire logic                                  o_out_err,
    input wire logic [tsp_pkg::MTY_W-1:0]             o_out_mty,
    input wire logic [tsp_pkg::DATA_W-1:0]            o_out_data
);
    // ****************************************
    // packet tracking, segment zero before one
    // ****************************************
    logic pkt_q;
    logic pkt_mid;
    logic pkt_d;
    logic bcw_q;

    always_comb
    begin
        pkt_mid = pkt_q;
        if (seg[0].vld)
            pkt_mid = (pkt_q | seg[0].sop) & !seg[0].eop;
        pkt_d = pkt_mid;
        if (seg[1].vld)
            pkt_d = (pkt_mid | seg[1].sop) & !seg[1].eop;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pkt_q <= 1'b0;
            bcw_q <= 1'b0;
        end
        else
        begin
            pkt_q <= pkt_d;
            if (o_out_vld && i_out_rdy)
                bcw_q <= o_out_bcw;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    vld_needs_rdy_a: assert property ((seg[0].vld || seg[1].vld) |-> rdy)
        else $error("segment valid while ready low");
    sop0_first_a: assert property (seg[0].vld && seg[0].sop |-> !pkt_q)
        else $error("start flag inside a packet on segment zero");
    sop1_first_a: assert property (seg[1].vld && seg[1].sop |-> !pkt_mid)
        else $error("start flag inside a packet on segment one");
    eop_in_pkt_a: assert property (seg[0].vld && seg[0].eop |-> pkt_q || seg[0].sop)
        else $error("end flag outside a packet");
    err_on_eop_a: assert property (seg[0].vld && seg[0].err |-> seg[0].eop)
        else $error("error flag without end flag");
    seg_order_a: assert property (seg[1].vld |-> seg[0].vld)
        else $error("segment one used without segment zero");
    no_ovf_a: assert property (!ovf)
        else $error("overflow with an obedient source");
    word_hold_a: assert property (o_out_vld && !i_out_rdy |=>
        o_out_vld && $stable(o_out_data) && $stable(o_out_bcw))
        else $error("stalled word changed");
    bcw_zero_a: assert property (o_out_vld && o_out_bcw |-> o_out_data == '0)
        else $error("control word carries payload");
    sop_after_bcw_a: assert property (o_out_vld && o_out_sop && !o_out_bcw |-> bcw_q)
        else $error("packet start not led by control word");
    mty_err_low_a: assert property (o_out_vld && o_out_eop && o_out_err |->
        o_out_mty[2:0] == 3'h0)
        else $error("low empty bits kept on errored end");
    mty_idle_a: assert property (o_out_vld && !o_out_eop && !o_out_bcw |-> o_out_mty == 4'h0)
        else $error("empty count outside an end word");
    err_idle_a: assert property (o_out_vld && !o_out_eop |-> !o_out_err)
        else $error("error flag outside an end word");
endmodule

// >>> test/tb.sv
// self-checking bench: source end and input end joined by one interface,
// a second input end driven directly to provoke back-pressure faults
// assumes the design files and tsp_chk are compiled first
`timescale 1ns/1ns
module tb;
    // ****************************************
    // signals
    // ****************************************
    localparam int MAX_BURST = 4;
    logic                i_ref_clk = 1'b0;
    logic                i_rst_n   = 1'b0;
    logic [3:0]          i_addr    = 4'h0;
    logic [31:0]         i_wdata   = 32'h0;
    logic                i_wr      = 1'b0;
    logic                i_rd      = 1'b0;
    logic [31:0]         o_rdata;
    logic                o_irq;
    logic [10:0]         chan_cfg  = 11'h0ff;
    logic                out_rdy   = 1'b0;
    logic                out_rdy_b = 1'b0;
    logic                out_vld, out_bcw, out_sop, out_eop, out_err, chan_bad;
    logic [3:0]          out_mty;
    logic [10:0]         out_chan;
    logic [127:0]        out_data;
    logic [18:0]         exp_q[$];
    logic [127:0]        dat_q[$];
    logic [127:0]        ed;
    logic [31:0]         rd_q[$];
    logic [31:0]         r;
    logic                rd_pend   = 1'b0;
    int                  err_count = 0;
    int                  cmp_count = 0;
    int                  seed      = 92;
    int                  bad_cnt   = 0;
    int                  low_cnt   = 0;
    int                  ovf_cnt   = 0;
    int                  early_ovf = 0;
    int                  i;
    int                  j;

    tsp_if bus();
    tsp_if bus_b();

    tsp_src u_tsp_src (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus.src), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
    tsp_dev #(.MAX_BURST(MAX_BURST)) u_tsp_dev (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .bus(bus.dev), .i_channel_range_cfg(chan_cfg), .i_out_rdy(out_rdy), .o_out_vld(out_vld),
        .o_out_bcw(out_bcw), .o_out_sop(out_sop), .o_out_eop(out_eop), .o_out_err(out_err),
        .o_out_mty(out_mty), .o_out_chan(out_chan), .o_out_data(out_data), .o_chan_bad(chan_bad));
    // second input end: the bench stands in for a source that ignores ready
    tsp_dev u_tsp_dev_b (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus_b.dev),
        .i_channel_range_cfg(11'h7ff), .i_out_rdy(out_rdy_b), .o_out_vld(), .o_out_bcw(),
        .o_out_sop(), .o_out_eop(), .o_out_err(), .o_out_mty(), .o_out_chan(),
        .o_out_data(), .o_chan_bad());
    tsp_chk u_tsp_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .seg(bus.seg), .rdy(bus.rdy),
        .ovf(bus.ovf), .i_out_rdy(out_rdy), .o_out_vld(out_vld), .o_out_bcw(out_bcw),
        .o_out_sop(out_sop), .o_out_eop(out_eop), .o_out_err(out_err), .o_out_mty(out_mty),
        .o_out_data(out_data));

    always #20 i_ref_clk = ~i_ref_clk;

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // an idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_ref_clk);
        i_wr    <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // expected words: control word first, one word per 16-byte segment
    task automatic send_pkt(input logic [10:0] ch, input int len, input logic bctl,
                            input logic er);
        int           n;
        int           k;
        int           b;
        logic [3:0]   m;
        logic [127:0] dv;
        n = (len + 15) / 16;
        m = 4'(n * 16 - len);
        if (er)
            m = {m[3], 3'h0};
        exp_q.push_back({1'b1, 7'h0, ch});
        dat_q.push_back('0);
        for (k = 0; k < n; k++)
        begin
            // a forced request puts a control word before every transfer
            if (k > 0 && (bctl || k % MAX_BURST == 0))
            begin
                exp_q.push_back({1'b1, 7'h0, ch});
                dat_q.push_back('0);
            end
            for (b = 0; b < 16; b++)
                dv[127 - 8 * b -: 8] = 8'(16 * k + b);
            dat_q.push_back(dv);
            exp_q.push_back({1'b0, k == 0, k == n - 1, er && k == n - 1,
                             (k == n - 1) ? m : 4'h0, ch});
        end
        wr(tsp_pkg::REG_CHAN, {21'h0, ch});
        wr(tsp_pkg::REG_LEN, 32'(len));
        wr(tsp_pkg::REG_CTRL, {29'h0, er, bctl, 1'b1});
        k = 0;
        while (exp_q.size() > 0 && k < 3000)
        begin
            @(posedge i_ref_clk);
            k++;
        end
        chk("words left", 32'h0, 32'(exp_q.size()));
    endtask

    // ****************************************
    // monitors
    // ****************************************
    always @(posedge i_ref_clk)
    begin
        out_rdy   <= ($random(seed) & 3) != 0;
        rd_pend   <= i_rd;
        if (rd_pend && rd_q.size() > 0)
            chk("read data", rd_q.pop_front(), o_rdata);
        if (out_vld && out_rdy)
        begin
            if (exp_q.size() == 0)
                chk("unexpected word", 32'h0, 32'h1);
            else
            begin
                ed = dat_q.pop_front();
                chk("word", {13'h0, exp_q.pop_front()}, {13'h0, out_bcw ?
                    {1'b1, 7'h0, out_chan} :
                    {1'b0, out_sop, out_eop, out_err, out_mty, out_chan}});
                for (j = 0; j < 4; j++)
                    chk("data", ed[32 * j +: 32], out_data[32 * j +: 32]);
            end
        end
        if (chan_bad)
            bad_cnt++;
        if (!bus_b.rdy)
            low_cnt++;
        if (bus_b.ovf)
            ovf_cnt++;
        if (bus_b.ovf && low_cnt == 0)
            early_ovf++;
    end

    initial
    begin
        repeat (40000) @(posedge i_ref_clk);
        err_count++;
        $display("watchdog expired");
        end_of_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        bus_b.seg <= '0;
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        rd(tsp_pkg::REG_STAT, 32'h0);
        rd(tsp_pkg::REG_MASK, 32'h0);
        rd(4'hf, 32'h0);
        $display("test registers done");
        send_pkt(11'h005, 37, 1'b0, 1'b1);
        send_pkt(11'h0ff, 90, 1'b1, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            r = $random(seed);
            send_pkt(r[10:0] & 11'h0ff, 1 + int'(r[31:16] % 16'd48), r[12], r[13]);
        end
        chk("channel flag idle", 32'h0, 32'(bad_cnt));
        send_pkt(11'h100, 20, 1'b0, 1'b0);
        chk("channel flag seen", 32'h1, {31'h0, bad_cnt > 0});
        $display("test packets done");
        rd(tsp_pkg::REG_STAT, 32'h1);
        chk("irq masked", 32'h0, {31'h0, o_irq});
        wr(tsp_pkg::REG_MASK, 32'h1);
        repeat (2) @(posedge i_ref_clk);
        chk("irq raised", 32'h1, {31'h0, o_irq});
        rd(tsp_pkg::REG_MASK, 32'h1);
        wr(tsp_pkg::REG_STAT, 32'h1);
        repeat (2) @(posedge i_ref_clk);
        chk("irq cleared", 32'h0, {31'h0, o_irq});
        rd(tsp_pkg::REG_STAT, 32'h0);
        $display("test interrupt done");
        // flood the second end with its drain stalled, ignoring ready
        for (i = 0; i < 12; i++)
        begin
            bus_b.seg[0].vld <= 1'b1;
            bus_b.seg[1].vld <= 1'b1;
            bus_b.seg[0].data <= {4{$random(seed)}};
            @(posedge i_ref_clk);
        end
        bus_b.seg[0].vld <= 1'b0;
        bus_b.seg[1].vld <= 1'b0;
        out_rdy_b <= 1'b1;
        repeat (30) @(posedge i_ref_clk);
        chk("ready fell", 32'h1, {31'h0, low_cnt > 0});
        chk("overflow seen", 32'h1, {31'h0, ovf_cnt > 0});
        chk("overflow early", 32'h0, 32'(early_ovf));
        chk("ready back", 32'h1, {31'h0, bus_b.rdy});
        $display("test overflow done");
        end_of_test();
    end
endmodule
